// file: dv/rwd_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none

`include "rwd_defines.svh"

module rwd_top_monitor
    import rwd_pkg::*;
#(
    parameter int CNT_WIDTH = 22,
    parameter int RST_CYCLES = 24
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire rwd_power_t power_state,
    input wire logic bus_release_ack_n,
    input wire logic runaway_interrupt,
    input wire logic internal_reset,
    input wire logic irq
);
    // =================================================================
    // Helper logic and sequences.
    logic [15:0] rst_cnt_ff;
    logic [15:0] nxt_rst_cnt;
    assign nxt_rst_cnt = internal_reset ? rst_cnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_cnt_ff <= 16'h0000;
        end else begin
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_clear;
        reg_wr && reg_addr == `RWD_ADDR_CMD && reg_wdata == 8'h4E;
    endsequence
    sequence s_mask_off;
        reg_wr && reg_addr == `RWD_ADDR_MASK && reg_wdata == 8'h00;
    endsequence

    // =================================================================
    // Assertions.
    a_rst_len_exact: assert property (
        $fell(internal_reset) |-> rst_cnt_ff == RST_CYCLES)
        else $error("internal reset length wrong");
    a_int_one_pulse: assert property (
        runaway_interrupt |=> !runaway_interrupt)
        else $error("runaway interrupt longer than one cycle");
    a_no_int_halt: assert property (
        runaway_interrupt |-> $past(power_state) == RWD_PWR_RUN)
        else $error("runaway interrupt outside run mode");
    a_int_bus_back: assert property (
        runaway_interrupt |-> $past(bus_release_ack_n))
        else $error("runaway interrupt during bus release");
    a_cmd_reads_zero: assert property (
        reg_rd && reg_addr == `RWD_ADDR_CMD |=> reg_rdata == 8'h00)
        else $error("command register not write only");
    a_clear_zeroes_count: assert property (
        s_clear ##1 (reg_rd && reg_addr == `RWD_ADDR_CNT_H) |=> reg_rdata == 8'h00)
        else $error("counter not cleared");
    a_mask_blocks_irq: assert property (
        s_mask_off ##1 !(reg_wr && reg_addr == `RWD_ADDR_MASK) |=> !irq)
        else $error("irq high with mask zero");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
endmodule : rwd_top_monitor

bind rwd_top rwd_top_monitor #(.CNT_WIDTH(CNT_WIDTH), .RST_CYCLES(RST_CYCLES)) u_mon (.*);

`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none

`include "rwd_defines.svh"

module tb;
    import rwd_pkg::*;
    localparam int RSTC = 24;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    rwd_power_t power_state = RWD_PWR_RUN;
    logic bus_release_ack_n = 1'b1;
    logic runaway_interrupt;
    logic internal_reset;
    logic irq;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int cnt;
    logic [7:0] rdv;
    logic [7:0] hold;
    logic [11:0] rows [7] = '{{4'h0, 8'h80}, {4'h3, 8'h00}, {4'h2, 8'h00},
        {4'h1, 8'h00}, {4'h4, 8'h01}, {4'hF, 8'h00}, {4'h8, 8'h00}};

    rwd_top #(.CNT_WIDTH(22), .RST_CYCLES(RSTC)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_state(power_state), .bus_release_ack_n(bus_release_ack_n),
        .runaway_interrupt(runaway_interrupt), .internal_reset(internal_reset), .irq(irq));

    always #50 clk = ~clk;

    // =================================================================
    // Shared tasks.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rdv = reg_rdata;
        chk(rdv, exp);
    endtask : rd

    task automatic stop_test;
        $display("mismatches=%0d checks=%0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 90000) begin
            bad_count++;
            stop_test();
        end
    end

    // =================================================================
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) rd(rows[i][11:8], rows[i][7:0]);
        wr(`RWD_ADDR_MASK, 8'h02);
        wr(`RWD_ADDR_CMD, 8'h12);
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        rd(`RWD_ADDR_STAT, 8'h02);
        rd(`RWD_ADDR_STAT, 8'h00);
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        wr(`RWD_ADDR_CMD, 8'hB1);
        rd(`RWD_ADDR_STATE, 8'h01);
        wr(`RWD_ADDR_MODE, 8'h00);
        rd(`RWD_ADDR_STATE, 8'h01);
        wr(`RWD_ADDR_CMD, 8'hB1);
        rd(`RWD_ADDR_STATE, 8'h00);
        rd(`RWD_ADDR_STAT, 8'h00);
        wr(`RWD_ADDR_MODE, 8'h80);
        rd(`RWD_ADDR_STATE, 8'h01);
        @(posedge clk);
        power_state <= RWD_PWR_LIGHT_HALT;
        rd(`RWD_ADDR_CNT_L, rdv);
        hold = rdv;
        repeat (10) @(posedge clk);
        rd(`RWD_ADDR_CNT_L, hold);
        @(posedge clk);
        power_state <= RWD_PWR_STOP;
        repeat (10) @(posedge clk);
        rd(`RWD_ADDR_CNT_L, hold);
        @(posedge clk);
        power_state <= RWD_PWR_PERIPHERAL_RUN_HALT;
        // Detection falls in the halt with the bus released, so both hold the interrupt back.
        wr(`RWD_ADDR_MODE, 8'h82);
        wr(`RWD_ADDR_MASK, 8'h01);
        bus_release_ack_n <= 1'b0;
        wr(`RWD_ADDR_CMD, 8'h4E);
        rd(`RWD_ADDR_CNT_H, 8'h00);
        cnt = 2;
        while (internal_reset !== 1'b1 && cnt < 66000) begin
            @(negedge clk);
            cnt++;
            if (runaway_interrupt !== 1'b0) chk(8'h01, 8'h00);
        end
        chk(8'(cnt >= 65536 && cnt <= 65542), 8'h01);
        cnt = 0;
        while (internal_reset === 1'b1 && cnt < 100) begin
            @(negedge clk);
            cnt++;
        end
        chk(8'(cnt), 8'(RSTC));
        chk({7'h00, irq}, 8'h01);
        rd(`RWD_ADDR_STATE, 8'h07);
        @(posedge clk);
        bus_release_ack_n <= 1'b1;
        repeat (4) begin
            @(negedge clk);
            chk({7'h00, runaway_interrupt}, 8'h00);
        end
        @(posedge clk);
        bus_release_ack_n <= 1'b0;
        power_state <= RWD_PWR_RUN;
        repeat (4) begin
            @(negedge clk);
            chk({7'h00, runaway_interrupt}, 8'h00);
        end
        @(posedge clk);
        bus_release_ack_n <= 1'b1;
        cnt = 0;
        while (runaway_interrupt !== 1'b1 && cnt < 4) begin
            @(negedge clk);
            cnt++;
        end
        chk({7'h00, runaway_interrupt}, 8'h01);
        rd(`RWD_ADDR_STAT, 8'h01);
        rd(`RWD_ADDR_STATE, 8'h03);
        chk({7'h00, irq}, 8'h00);
        wr(`RWD_ADDR_CMD, 8'h4E);
        rd(`RWD_ADDR_STATE, 8'h01);
        wr(`RWD_ADDR_MASK, 8'h00);
        wr(`RWD_ADDR_CMD, 8'h12);
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        rd(`RWD_ADDR_STAT, 8'h02);
        stop_test();
    end
endmodule : tb

`default_nettype wire

// file: logic/rwd_defines.svh
`ifndef RWD_DEFINES_SVH
`define RWD_DEFINES_SVH

// =====================================================================
// Register offsets.
`define RWD_ADDR_MODE 4'h0
`define RWD_ADDR_CMD 4'h1
`define RWD_ADDR_STAT 4'h2
`define RWD_ADDR_MASK 4'h3
`define RWD_ADDR_STATE 4'h4
`define RWD_ADDR_CNT_L 4'h5
`define RWD_ADDR_CNT_M 4'h6
`define RWD_ADDR_CNT_H 4'h7

// =====================================================================
// Field positions.
`define RWD_MODE_EN_BIT 7
`define RWD_MODE_SEL_LSB 5
`define RWD_MODE_HALT_LSB 2
`define RWD_MODE_RESET_ON_RUNAWAY_BIT 1
`define RWD_STAT_RUNAWAY_BIT 0
`define RWD_STAT_BADCMD_BIT 1
`define RWD_STATE_RUNNING_BIT 0
`define RWD_STATE_DETECT_BIT 1
`define RWD_STATE_PEND_BIT 2

// =====================================================================
// Reset values and command codes.
`define RWD_MODE_RESET 8'h80
`define RWD_MASK_RESET 8'h00
`define RWD_STAT_RESET 8'h00
`define RWD_CODE_CLEAR 8'h4E
`define RWD_CODE_DISABLE 8'hB1

// =====================================================================
// Timing counts.
`define RWD_CNT_WIDTH 22
`define RWD_OSC_PER_COUNT 2
`define RWD_TAP_BASE 15
`define RWD_RST_STATES 12
`define RWD_OSC_PER_STATE 2
`define RWD_RST_CYCLES (`RWD_RST_STATES * `RWD_OSC_PER_STATE)

`endif

// file: logic/rwd_pkg.sv
package rwd_pkg;

    // =================================================================
    // Power modes reported by the clock controller.
    typedef enum logic [1:0] {
        RWD_PWR_RUN = 2'b00,
        RWD_PWR_PERIPHERAL_RUN_HALT = 2'b01,
        RWD_PWR_LIGHT_HALT = 2'b10,
        RWD_PWR_STOP = 2'b11
    } rwd_power_t;

    // =================================================================
    // Watchdog supervision state.
    typedef enum logic [1:0] {
        RWD_ST_ARMED = 2'b00,
        RWD_ST_DETECTED = 2'b01,
        RWD_ST_DISABLED = 2'b10
    } rwd_state_t;

endpackage : rwd_pkg

// file: logic/rwd_reset_stretch.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Internal reset pulse stretcher.
module rwd_reset_stretch
    import rwd_pkg::*;
#(
    parameter int CYCLES = 24
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic trigger,
    output logic rst_out
);

    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic rst_out_ff;
    logic nxt_rst_out;
    wire logic cnt_done;

    assign cnt_done = (cnt_ff == 8'h01);
    assign nxt_cnt = trigger ? CYCLES[7:0] : (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    assign nxt_rst_out = trigger | (rst_out_ff & ~cnt_done);
    assign rst_out = rst_out_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= 8'h00;
            rst_out_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            rst_out_ff <= nxt_rst_out;
        end
    end

endmodule : rwd_reset_stretch

`default_nettype wire

// file: logic/rwd_top.sv
// Operation
// - A 22-bit binary counter advances once per two oscillator periods.
// - Reaching the detection time uncleared raises the non-maskable runaway interrupt.
// - Detection time select resets to 00, the 2^16 period.
// - Select chooses 2^16, 2^18, 2^20 or 2^22 oscillator periods.
// - The enable bit resets to 1, so the watchdog runs by default.
// - Disabling needs enable bit cleared first, then disable code B1H.
// - Setting the enable bit again re-enables without any code write.
// - With reset-on-runaway set, a runaway forces an internal reset; bit resets 0.
// - Without reset-on-runaway, the detected state holds until the clear code.
// - Writing 4EH clears the counter to zero; counting resumes.
// - Uncleared, the runaway interrupt recurs every twice the detection time.
// - The internal reset stays asserted between 8 and 20 states.
// - Counter runs in run and peripheral-run halt, stops in light halt and stop.
// - No runaway interrupt is delivered during peripheral-run halt; software should disable first.
// - Counting continues during bus release; interrupt follows right after release.
// - Counting starts right after chip reset release.
`timescale 1ns/100ps
`default_nettype none

`include "rwd_defines.svh"

module rwd_top
    import rwd_pkg::*;
#(
    parameter int CNT_WIDTH = `RWD_CNT_WIDTH,
    parameter int RST_CYCLES = `RWD_RST_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire rwd_power_t power_state,
    input wire logic bus_release_ack_n,
    output logic runaway_interrupt,
    output logic internal_reset,
    output logic irq
);

    // =================================================================
    // Registers.
    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    rwd_state_t state_ff;
    rwd_state_t nxt_state;
    logic [CNT_WIDTH-1:0] cnt_ff;
    logic [CNT_WIDTH-1:0] nxt_cnt;
    logic presc_ff;
    logic nxt_presc;
    logic tap_prev_ff;
    logic nxt_tap_prev;
    logic pend_ff;
    logic nxt_pend;
    logic nmi_ff;
    logic nxt_nmi;
    logic irq_ff;
    logic nxt_irq;
    logic rst_trig_ff;
    logic nxt_rst_trig;

    // =================================================================
    // Bus decode.
    wire logic sel_mode;
    wire logic sel_cmd;
    wire logic sel_stat;
    wire logic sel_mask;
    wire logic wr_mode;
    wire logic wr_cmd;
    wire logic wr_mask;
    wire logic rd_stat;
    wire logic code_clear;
    wire logic code_disable;
    wire logic code_bad;

    assign sel_mode = (reg_addr == `RWD_ADDR_MODE);
    assign sel_cmd = (reg_addr == `RWD_ADDR_CMD);
    assign sel_stat = (reg_addr == `RWD_ADDR_STAT);
    assign sel_mask = (reg_addr == `RWD_ADDR_MASK);
    assign wr_mode = reg_wr & sel_mode;
    assign wr_cmd = reg_wr & sel_cmd;
    assign wr_mask = reg_wr & sel_mask;
    assign rd_stat = reg_rd & sel_stat;

    assign code_clear = wr_cmd & (reg_wdata == `RWD_CODE_CLEAR);
    assign code_disable = wr_cmd & (reg_wdata == `RWD_CODE_DISABLE);
    assign code_bad = wr_cmd & ~code_clear & ~code_disable;

    // =================================================================
    // Mode fields.
    wire logic en_bit;
    wire logic [1:0] time_sel;
    wire logic reset_on_runaway_bit;
    wire logic en_write_one;

    assign en_bit = mode_ff[`RWD_MODE_EN_BIT];
    assign time_sel = mode_ff[`RWD_MODE_SEL_LSB +: 2];
    assign reset_on_runaway_bit = mode_ff[`RWD_MODE_RESET_ON_RUNAWAY_BIT];
    assign en_write_one = wr_mode & reg_wdata[`RWD_MODE_EN_BIT];

    assign nxt_mode = wr_mode ? reg_wdata : mode_ff;

    assign nxt_mask = wr_mask ? reg_wdata : mask_ff;

    // =================================================================
    // Supervision state.
    // The detection strobe is declared here because the state machine reads it.
    wire logic runaway_event;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            RWD_ST_ARMED: begin
                // code only honoured after enable bit cleared
                if (code_disable && !en_bit) begin
                    nxt_state = RWD_ST_DISABLED;
                end else if (runaway_event) begin
                    nxt_state = RWD_ST_DETECTED;
                end
            end
            RWD_ST_DETECTED: begin
                if (code_disable && !en_bit) begin
                    nxt_state = RWD_ST_DISABLED;
                end else if (code_clear) begin
                    nxt_state = RWD_ST_ARMED;
                end
            end
            RWD_ST_DISABLED: begin
                if (en_write_one) begin
                    nxt_state = RWD_ST_ARMED;
                end
            end
            default: begin
                nxt_state = RWD_ST_ARMED;
            end
        endcase
    end

    // =================================================================
    // Counter.
    wire logic running;
    wire logic mode_counts;
    wire logic counting;
    wire logic count_step;
    wire logic [4:0] tap_index;
    wire logic tap_bit;

    assign running = (state_ff != RWD_ST_DISABLED);

    // counts only in run and peripheral-run halt
    // bus release does not stop the count
    assign mode_counts = (power_state == RWD_PWR_RUN) ||
                         (power_state == RWD_PWR_PERIPHERAL_RUN_HALT);
    assign counting = running & mode_counts;

    // one count per two oscillator periods
    assign count_step = counting & presc_ff;
    assign nxt_presc = (code_clear | ~running) ? 1'b0 : counting ? ~presc_ff : presc_ff;

    assign nxt_cnt = (code_clear | ~running) ? '0 :
                     count_step ? cnt_ff + {{(CNT_WIDTH-1){1'b0}}, 1'b1} : cnt_ff;

    // tap at bit 15, 17, 19 or 21
    assign tap_index = 5'(`RWD_TAP_BASE) + {2'b00, time_sel, 1'b0};
    assign tap_bit = cnt_ff[tap_index];
    assign nxt_tap_prev = (code_clear | ~running) ? 1'b0 : tap_bit;

    // rising tap bit is a detection
    // tap rises once per two detection times
    assign runaway_event = running & tap_bit & ~tap_prev_ff;

    // =================================================================
    // Interrupt delivery.
    wire logic deliver_ok;

    // held back while the bus is released
    assign deliver_ok = (power_state == RWD_PWR_RUN) & bus_release_ack_n;

    // Pending detection survives the halt so it fires on release.
    assign nxt_pend = (runaway_event | pend_ff) & ~deliver_ok & running;

    assign nxt_nmi = deliver_ok & (runaway_event | pend_ff);

    assign nxt_rst_trig = runaway_event & reset_on_runaway_bit;

    // =================================================================
    // Status, mask and the level interrupt.
    wire logic [7:0] stat_set;
    wire logic [7:0] stat_kept;

    assign stat_set = (8'(runaway_event) << `RWD_STAT_RUNAWAY_BIT) |
                      (8'(code_bad) << `RWD_STAT_BADCMD_BIT);
    // A read clears, but an event in the same cycle wins.
    assign stat_kept = rd_stat ? 8'h00 : stat_ff;
    assign nxt_stat = stat_kept | stat_set;
    assign nxt_irq = |(nxt_stat & mask_ff);

    // =================================================================
    // Read data.
    wire logic [7:0] state_view;
    wire logic [CNT_WIDTH+1:0] cnt_wide;

    assign state_view = (8'(running) << `RWD_STATE_RUNNING_BIT) |
                        (8'(state_ff == RWD_ST_DETECTED) << `RWD_STATE_DETECT_BIT) |
                        (8'(pend_ff) << `RWD_STATE_PEND_BIT);
    assign cnt_wide = {2'b00, cnt_ff};

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `RWD_ADDR_MODE: nxt_rdata = mode_ff;
                `RWD_ADDR_STAT: nxt_rdata = stat_ff;
                `RWD_ADDR_MASK: nxt_rdata = mask_ff;
                `RWD_ADDR_STATE: nxt_rdata = state_view;
                `RWD_ADDR_CNT_L: nxt_rdata = cnt_wide[7:0];
                `RWD_ADDR_CNT_M: nxt_rdata = cnt_wide[15:8];
                `RWD_ADDR_CNT_H: nxt_rdata = cnt_wide[23:16];
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // =================================================================
    // Flip-flops.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff <= `RWD_MODE_RESET;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_ff <= `RWD_MASK_RESET;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_ff <= `RWD_STAT_RESET;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= RWD_ST_ARMED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc_ff <= 1'b0;
        end else begin
            presc_ff <= nxt_presc;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tap_prev_ff <= 1'b0;
        end else begin
            tap_prev_ff <= nxt_tap_prev;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_ff <= 1'b0;
        end else begin
            nmi_ff <= nxt_nmi;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_trig_ff <= 1'b0;
        end else begin
            rst_trig_ff <= nxt_rst_trig;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // =================================================================
    // Internal reset.
    // twelve states, inside the 8 to 20 window
    rwd_reset_stretch #(
        .CYCLES(RST_CYCLES)
    ) u_stretch (
        .clk(clk),
        .sys_rst(sys_rst),
        .trigger(rst_trig_ff),
        .rst_out(internal_reset)
    );

    assign reg_rdata = rdata_ff;
    assign runaway_interrupt = nmi_ff;
    assign irq = irq_ff;

endmodule : rwd_top

`default_nettype wire
